// ==== hdl/ctlh_sync.sv ====
// two-stage synchroniser for the device's response pins
`timescale 1ns/1ns
module ctlh_sync #(
    parameter int W = 1
) (
    input  wire logic         clock_i,
    input  wire logic         sys_rst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    import ctlh_pkg::*;

    // ------------------------------------------------------------------
    // per bit: first stage feeds only the second
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic meta_r;
            logic hold_r;
            always_ff @(posedge clock_i) begin
                if (sys_rst_i) begin
                    meta_r <= 1'b1;
                    hold_r <= 1'b1;
                end else begin
                    meta_r <= async_i[g];
                    hold_r <= meta_r;
                end
            end
            assign sync_o[g] = hold_r;
        end
    endgenerate

endmodule : ctlh_sync

// ==== hdl/ctlh_tag_host.sv ====
// host controller that drives a cache tag store through its pins
//
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Overview of operation
// - cpu lookups update LRU, monitor lookups do not
// - cpu lookup miss is followed by tag write
// - tag write: store and lru update low together
// - lru update held high during purge
// - lookup integrity error counts as miss, then flush
// ----------------------------------------------------------------------
module ctlh_tag_host (
    input  wire logic              clock_i,
    input  wire logic              sys_rst_i,
    input  wire logic [3:0]        avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    output logic      [31:0]       avs_readdata_o,
    output logic                   avs_waitrequest_o,
    output ctlh_pkg::ctlh_pins_t   pins_o,
    input  wire ctlh_pkg::ctlh_resp_t resp_i
);
    import ctlh_pkg::*;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    ctlh_state_t      state_r;
    ctlh_state_t      state_nxt;
    ctlh_op_t         op_r;
    ctlh_op_t         op_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [9:0]       index_r;
    logic [19:0]      tag_r;
    logic [1:0]       way_force_r;
    logic             alloc_en_r;
    logic             recover_en_r;
    logic             hit_r;
    logic             err_r;
    logic [3:0]       way_r;
    logic             alloc_done_r;
    logic             recover_done_r;
    logic             rd_ack_r;
    logic [31:0]      readdata_r;
    ctlh_pins_t       pins_r;
    ctlh_resp_t       resp_s;
    logic [RESP_W-1:0] resp_sync;
    logic             busy;
    logic             ctrl_wr;
    logic             go;
    logic             cnt_done;
    logic             sample;
    logic             is_lookup;
    logic             follow_recover;
    logic             follow_alloc;

    // ------------------------------------------------------------------
    // response pins cross into the clock domain
    // ------------------------------------------------------------------
    ctlh_sync #(.W(RESP_W)) u_sync (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .async_i   (resp_i),
        .sync_o    (resp_sync)
    );
    assign resp_s = ctlh_resp_t'(resp_sync);

    // ------------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------------
    assign busy    = (state_r != ST_IDLE);
    assign ctrl_wr = avs_write_i && (avs_address_i == REG_CTRL);
    // a command write stalls the master until the previous command ends
    assign go      = ctrl_wr && !busy;
    assign avs_waitrequest_o = (avs_read_i && !rd_ack_r) || (ctrl_wr && busy);
    assign avs_readdata_o    = readdata_r;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            index_r      <= INDEX_RST;
            tag_r        <= TAG_RST;
            way_force_r  <= 2'h0;
            alloc_en_r   <= 1'b0;
            recover_en_r <= 1'b0;
        end else if (avs_write_i) begin
            if (avs_address_i == REG_INDEX) begin
                index_r <= avs_writedata_i[9:0];
            end
            if (avs_address_i == REG_TAG) begin
                tag_r <= avs_writedata_i[19:0];
            end
            if (go) begin
                way_force_r  <= avs_writedata_i[CTRL_WF_LSB +: 2];
                alloc_en_r   <= avs_writedata_i[CTRL_ALLOC];
                recover_en_r <= avs_writedata_i[CTRL_RECOVER];
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rd_ack_r   <= 1'b0;
            readdata_r <= 32'h00000000;
        end else begin
            rd_ack_r <= avs_read_i && !rd_ack_r;
            if (avs_read_i && !rd_ack_r) begin
                case (avs_address_i)
                    REG_INDEX:  readdata_r <= {22'h000000, index_r};
                    REG_TAG:    readdata_r <= {12'h000, tag_r};
                    REG_CTRL:   readdata_r <= {25'h0000000, way_force_r,
                                               recover_en_r, alloc_en_r, op_r};
                    REG_STATUS: readdata_r <= {23'h000000, recover_done_r, alloc_done_r,
                                               way_r, err_r, hit_r, busy};
                    default:    readdata_r <= 32'h00000000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    assign cnt_done  = (cnt_r == '0);
    assign is_lookup = (op_r == OP_LOOKUP_CPU) || (op_r == OP_LOOKUP_MON);
    assign sample    = (state_r == ST_SETUP) && cnt_done &&
                       (is_lookup || op_r == OP_INV_IMPL);
    // an integrity error outranks allocation: flushing instead avoids a bad slot
    assign follow_recover = is_lookup && err_r && recover_en_r;
    assign follow_alloc   = (op_r == OP_LOOKUP_CPU) && !hit_r && alloc_en_r;

    always_comb begin
        state_nxt = state_r;
        op_nxt    = op_r;
        case (state_r)
            ST_IDLE: begin
                if (go) begin
                    state_nxt = ST_SETUP;
                    op_nxt    = ctlh_op_t'(avs_writedata_i[CTRL_OP_LSB +: 3]);
                end
            end
            ST_SETUP: begin
                if (cnt_done) begin
                    state_nxt = ST_STROBE;
                end
            end
            ST_STROBE: begin
                if (cnt_done) begin
                    state_nxt = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                if (follow_recover) begin
                    state_nxt = ST_SETUP;
                    op_nxt    = OP_PURGE;
                end else if (follow_alloc) begin
                    state_nxt = ST_SETUP;
                    op_nxt    = OP_TAG_WRITE;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state_r <= ST_IDLE;
            op_r    <= OP_LOOKUP_MON;
            cnt_r   <= '0;
        end else begin
            state_r <= state_nxt;
            op_r    <= op_nxt;
            if (state_nxt == ST_SETUP && state_r != ST_SETUP) begin
                cnt_r <= CNT_W'(SETUP_CYC - 1);
            end else if (state_nxt == ST_STROBE && state_r != ST_STROBE) begin
                cnt_r <= CNT_W'(STROBE_CYC - 1);
            end else if (!cnt_done) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // lookup result capture
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            hit_r <= 1'b0;
            err_r <= 1'b0;
            way_r <= 4'h0;
        end else if (sample) begin
            // an access flagged by the integrity output never counts as a hit
            hit_r <= !resp_s.match_n && resp_s.integrity_err_n;
            err_r <= !resp_s.integrity_err_n;
            way_r <= resp_s.way_select_out;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            alloc_done_r   <= 1'b0;
            recover_done_r <= 1'b0;
        end else if (go) begin
            alloc_done_r   <= 1'b0;
            recover_done_r <= 1'b0;
        end else if (state_r == ST_RELEASE) begin
            if (follow_recover) begin
                recover_done_r <= 1'b1;
            end else if (follow_alloc) begin
                alloc_done_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // pin drive, registered from the next state
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            pins_r <= '{tag_in: TAG_RST, index_addr: INDEX_RST, store_n: 1'b1,
                        flush_all_n: 1'b1, invalidate_n: 1'b1, suppress_n: 1'b1,
                        lru_update_n: 1'b1, way_force0: 1'b0, way_force1: 1'b0,
                        hit_rep_sel: 1'b1};
        end else begin
            // idle and setup leave every strobe high, which is a plain lookup
            pins_r.store_n      <= 1'b1;
            pins_r.flush_all_n  <= 1'b1;
            pins_r.invalidate_n <= 1'b1;
            pins_r.suppress_n   <= 1'b1;
            pins_r.lru_update_n <= 1'b1;
            pins_r.index_addr   <= index_r;
            pins_r.tag_in       <= tag_r;
            pins_r.way_force0   <= way_force_r[0];
            pins_r.way_force1   <= way_force_r[1];
            // replace information for every tag write, allocating or commanded, hit otherwise
            pins_r.hit_rep_sel  <= (op_nxt != OP_TAG_WRITE);
            if (state_nxt == ST_STROBE) begin
                case (op_nxt)
                    OP_LOOKUP_CPU: pins_r.lru_update_n <= 1'b0;
                    OP_LOOKUP_MON: pins_r.lru_update_n <= 1'b1;
                    OP_TAG_WRITE: begin
                        pins_r.store_n      <= 1'b0;
                        pins_r.lru_update_n <= 1'b0;
                    end
                    OP_INV_IMPL:  pins_r.invalidate_n <= 1'b0;
                    OP_INV_EXPL: begin
                        // way force selects the element, no tag match needed
                        pins_r.invalidate_n <= 1'b0;
                        pins_r.suppress_n   <= 1'b0;
                    end
                    OP_PURGE: begin
                        pins_r.flush_all_n  <= 1'b0;
                        pins_r.lru_update_n <= 1'b1;
                    end
                    default: pins_r.lru_update_n <= 1'b1;
                endcase
            end
        end
    end

    assign pins_o = pins_r;

endmodule : ctlh_tag_host

// ==== include/ctlh_pkg.sv ====
// package for the tag store host controller: pin bundles, register map, timing
package ctlh_pkg;

    // ------------------------------------------------------------------
    // pin bundles
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [19:0] tag_in;
        logic [9:0]  index_addr;
        logic        store_n;
        logic        flush_all_n;
        logic        invalidate_n;
        logic        suppress_n;
        logic        lru_update_n;
        logic        way_force0;
        logic        way_force1;
        logic        hit_rep_sel;
    } ctlh_pins_t;

    typedef struct packed {
        logic       match_n;
        logic [3:0] way_select_out;
        logic       integrity_err_n;
    } ctlh_resp_t;

    localparam int RESP_W = 6;

    // ------------------------------------------------------------------
    // operations and states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_LOOKUP_CPU = 3'h0,
        OP_LOOKUP_MON = 3'h1,
        OP_TAG_WRITE  = 3'h2,
        OP_INV_IMPL   = 3'h3,
        OP_INV_EXPL   = 3'h4,
        OP_PURGE      = 3'h5
    } ctlh_op_t;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'h1,
        ST_SETUP   = 4'h2,
        ST_STROBE  = 4'h4,
        ST_RELEASE = 4'h8
    } ctlh_state_t;

    // ------------------------------------------------------------------
    // register map (byte addresses) and fields
    // ------------------------------------------------------------------
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_INDEX  = 4'h4;
    localparam logic [3:0] REG_TAG    = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hC;

    localparam int CTRL_OP_LSB    = 0;
    localparam int CTRL_ALLOC     = 3;
    localparam int CTRL_RECOVER   = 4;
    localparam int CTRL_WF_LSB    = 5;
    localparam int STAT_BUSY      = 0;
    localparam int STAT_HIT       = 1;
    localparam int STAT_ERR       = 2;
    localparam int STAT_WAY_LSB   = 3;
    localparam int STAT_ALLOC     = 7;
    localparam int STAT_RECOVER   = 8;

    localparam logic [9:0]  INDEX_RST = 10'h000;
    localparam logic [19:0] TAG_RST   = 20'h00000;

    // ------------------------------------------------------------------
    // timing at 10 MHz
    // ------------------------------------------------------------------
    localparam int CLK_NS       = 100;
    localparam int ACCESS_NS    = 100;
    localparam int STROBE_NS    = 200;
    localparam int SYNC_STAGES  = 2;
    localparam int SETUP_CYC    = (ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
    localparam int STROBE_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W        = 4;

endpackage : ctlh_pkg

// ==== test/ctlh_store_model.sv ====
// behavioural two-way tag store answering the host's pin levels
`timescale 1ns/1ns
module ctlh_store_model
    import ctlh_pkg::*;
(
    input  wire ctlh_pkg::ctlh_pins_t pins_i,
    input  wire logic                 inject_i,
    output ctlh_pkg::ctlh_resp_t      resp_o
);
    logic [19:0] tag_r [0:1023][0:1];
    logic [1:0]  v0_r  [0:1023];
    logic [1:0]  v1_r  [0:1023];
    logic [1:0]  par_r [0:1023];
    logic        lru_r [0:1023];
    logic [1:0]  hit;
    logic [1:0]  pe;
    logic [9:0]  ix;
    logic        w;
    assign ix = pins_i.index_addr;
    always_comb begin
        for (int k = 0; k < 2; k++) begin
            hit[k] = v0_r[ix][k] & v1_r[ix][k] &
                     (tag_r[ix][k] == pins_i.tag_in);
            pe[k]  = (v0_r[ix][k] ^ v1_r[ix][k]) |
                     (v0_r[ix][k] & (^tag_r[ix][k] ^ par_r[ix][k]));
        end
    end
    assign resp_o.match_n         = ~|hit;
    assign resp_o.integrity_err_n = ~|pe;
    // replace information names the element that the next tag write fills
    assign resp_o.way_select_out  =
        {2'h0, pins_i.hit_rep_sel ? hit : {lru_r[ix], !lru_r[ix]}};
    // purge acts on the falling edge and wins over every other strobe
    always @(negedge pins_i.flush_all_n) begin
        for (int i = 0; i < 1024; i++) begin
            v0_r[i]  = 2'h0;
            v1_r[i]  = 2'h0;
            lru_r[i] = 1'h0;
        end
    end
    always @(negedge pins_i.store_n) begin
        #1;
        if (pins_i.flush_all_n) begin
            w = lru_r[ix];
            tag_r[ix][w] = pins_i.tag_in;
            par_r[ix][w] = ^pins_i.tag_in;
            v0_r[ix][w] = 1'h1;
            v1_r[ix][w] = 1'h1;
            lru_r[ix] = !w;
        end
    end
    // a miss leaves tags, validity and lru alone
    always @(negedge pins_i.invalidate_n) begin
        #1;
        if (pins_i.flush_all_n && (!pins_i.suppress_n || hit != 2'h0)) begin
            w = pins_i.suppress_n ? hit[1] : pins_i.way_force0;
            v0_r[ix][w] = 1'h0;
            v1_r[ix][w] = 1'h0;
            if (pins_i.suppress_n) lru_r[ix] = w;
        end
    end
    always @(negedge pins_i.lru_update_n) begin
        #1;
        if (pins_i.store_n && pins_i.flush_all_n && pins_i.invalidate_n && hit != 2'h0)
            lru_r[ix] = !hit[1];
    end
    // soft error: flips one validity copy so the duplicates disagree
    always @(posedge inject_i) v1_r[ix][0] = !v1_r[ix][0];
endmodule : ctlh_store_model

// ==== test/ctlh_tag_host_bench.sv ====
// self-checking bench for the tag store host controller
`timescale 1ns/1ns
module ctlh_tag_host_bench;
    import ctlh_pkg::*;
    typedef struct { string nm; logic [31:0] m; logic [31:0] v; } ctlh_exp_t;
    logic        clock_i, sys_rst_i, avs_read_i, avs_write_i, avs_waitrequest_o, inject;
    logic [3:0]  avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, rd_d;
    logic [9:0]  ix;
    logic [19:0] tg, t2;
    ctlh_pins_t  pins;
    ctlh_resp_t  resp;
    ctlh_exp_t   q[$];
    ctlh_exp_t   e;
    int          error_cnt = 0;
    int          n_checks = 0;
    ctlh_tag_host u_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .pins_o(pins), .resp_i(resp));
    ctlh_store_model u_dev (.pins_i(pins), .inject_i(inject), .resp_o(resp));
    initial begin
        clock_i = 1'h0;
        forever #50 clock_i = ~clock_i;
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish;
        if (error_cnt == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    // one bus transfer; an idle edge follows so requests never merge
    task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
        int n;
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_read_i <= rd;
        avs_write_i <= !rd;
        for (n = 0; n < 100; n++) begin
            @(posedge clock_i);
            if (avs_waitrequest_o === 1'h0) break;
        end
        rd_d = avs_readdata_o;
        if (n == 100) begin
            error_cnt++;
            tally_and_finish();
        end
        avs_read_i <= 1'h0;
        avs_write_i <= 1'h0;
        @(posedge clock_i);
    endtask : bus
    task automatic exp_rd(input string nm, input logic [3:0] a, input logic [31:0] m,
                          input logic [31:0] v);
        q.push_back('{nm, m, v});
        bus(1'h1, a, 32'h0);
    endtask : exp_rd
    // busy must read clear twice running, as chained follow-ups may start
    task automatic cmd(input logic [9:0] i, input logic [19:0] t, input logic [31:0] c);
        int k = 0;
        bus(1'h0, REG_INDEX, {22'h0, i});
        bus(1'h0, REG_TAG, {12'h0, t});
        bus(1'h0, REG_CTRL, c);
        for (int n = 0; n < 40 && k < 2; n++) begin
            bus(1'h1, REG_STATUS, 32'h0);
            k = (rd_d[STAT_BUSY] === 1'h0) ? k + 1 : 0;
        end
        if (k < 2) begin
            error_cnt++;
            tally_and_finish();
        end
    endtask : cmd
    task automatic look(input logic [19:0] t, input logic [31:0] c, input logic h);
        cmd(ix, t, c);
        exp_rd("status hit", REG_STATUS, 32'h6, {30'h0, h, 1'h0});
    endtask : look
    always @(posedge clock_i) begin
        if (avs_read_i === 1'h1 && avs_waitrequest_o === 1'h0 && q.size() > 0) begin
            e = q.pop_front();
            check(e.nm, avs_readdata_o & e.m, e.v);
        end
    end
    initial begin
        sys_rst_i = 1'h1;
        avs_read_i = 1'h0;
        avs_write_i = 1'h0;
        avs_address_i = 4'h0;
        avs_writedata_i = 32'h0;
        inject = 1'h0;
        void'($urandom(32'hE4C5));
        repeat (2) @(posedge clock_i);
        sys_rst_i <= 1'h0;
        exp_rd("index", REG_INDEX, 32'hFFFFFFFF, 32'h0);
        exp_rd("tag", REG_TAG, 32'hFFFFFFFF, 32'h0);
        bus(1'h0, REG_STATUS, 32'hFFFFFFFF);
        exp_rd("status", REG_STATUS, 32'hFFFFFFFF, 32'h0);
        exp_rd("unmapped", 4'h2, 32'hFFFFFFFF, 32'h0);
        bus(1'h0, REG_CTRL, 32'h5);
        bus(1'h0, REG_CTRL, 32'h5);
        for (int r = 0; r < 3; r++) begin
            ix = 10'($urandom);
            tg = 20'($urandom);
            t2 = tg ^ 20'($urandom | 1);
            cmd(ix, tg, 32'h5);
            look(tg, 32'h0, 1'h0);
            cmd(ix, tg, 32'h2);
            look(tg, 32'h1, 1'h1);
            look(t2, 32'h1, 1'h0);
            look(t2, 32'h3, 1'h0);
            look(tg, 32'h0, 1'h1);
            look(tg, 32'h3, 1'h1);
            look(tg, 32'h1, 1'h0);
            cmd(ix, tg, 32'h2);
            cmd(ix, t2, 32'h2);
            look(tg, 32'h0, 1'h1);
            cmd(ix, t2 ^ 20'h80000, 32'h2);
            look(tg, 32'h1, 1'h1);
            exp_rd("status way", REG_STATUS, 32'h78, 32'h08);
            look(t2, 32'h1, 1'h0);
            cmd(ix, tg, 32'h4);
            cmd(ix, tg, 32'h24);
            exp_rd("ctrl", REG_CTRL, 32'h7F, 32'h24);
            look(tg, 32'h1, 1'h0);
        end
        cmd(ix, t2, 32'h8);
        exp_rd("alloc done", REG_STATUS, 32'h186, 32'h80);
        look(t2, 32'h1, 1'h1);
        inject <= 1'h1;
        @(posedge clock_i);
        inject <= 1'h0;
        cmd(ix, t2, 32'h10);
        exp_rd("recovery", REG_STATUS, 32'h106, 32'h104);
        look(t2, 32'h0, 1'h0);
        tally_and_finish();
    end
endmodule : ctlh_tag_host_bench

// ==== test/ctlh_tag_host_monitor.sv ====
// assertion checker on the host controller ports
`timescale 1ns/1ns
module ctlh_tag_host_monitor
    import ctlh_pkg::*;
(
    input wire logic                 clock_i,
    input wire logic                 sys_rst_i,
    input wire logic [3:0]           avs_address_i,
    input wire logic                 avs_read_i,
    input wire logic                 avs_write_i,
    input wire logic [31:0]          avs_writedata_i,
    input wire logic                 avs_waitrequest_o,
    input wire ctlh_pkg::ctlh_pins_t pins_o,
    input wire ctlh_pkg::ctlh_resp_t resp_i
);
    logic mon_r;
    logic alloc_r;
    logic rec_r;
    // ----------------------------------------
    // flags of the last accepted command
    // ----------------------------------------
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            mon_r   <= 1'h0;
            alloc_r <= 1'h0;
            rec_r   <= 1'h0;
        end else if (avs_write_i && !avs_waitrequest_o && avs_address_i == REG_CTRL) begin
            mon_r   <= avs_writedata_i[2:0] == 3'h1;
            alloc_r <= avs_writedata_i[CTRL_ALLOC];
            rec_r   <= avs_writedata_i[CTRL_RECOVER];
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_pulse2(x); !x ##1 x; endsequence
    sequence s_cpu_look;
        !pins_o.lru_update_n && pins_o.store_n ##1 pins_o.lru_update_n;
    endsequence
    property p_wr;
        !pins_o.store_n |-> !pins_o.lru_update_n && pins_o.invalidate_n &&
            pins_o.flush_all_n && pins_o.suppress_n;
    endproperty
    a_wr: assert property (p_wr) else $error("tag write strobes wrong");
    // a tag write must present replace information, or the hit element is refilled
    property p_wr_rep; !pins_o.store_n |-> !pins_o.hit_rep_sel; endproperty
    a_wr_rep: assert property (p_wr_rep) else $error("tag write without replace select");
    property p_wr_len; $fell(pins_o.store_n) |=> s_pulse2(pins_o.store_n); endproperty
    a_wr_len: assert property (p_wr_len) else $error("store strobe length wrong");
    property p_purge_lru; !pins_o.flush_all_n |-> pins_o.lru_update_n; endproperty
    a_purge_lru: assert property (p_purge_lru) else $error("lru update during purge");
    property p_inv_len; $fell(pins_o.invalidate_n) |=> s_pulse2(pins_o.invalidate_n); endproperty
    a_inv_len: assert property (p_inv_len) else $error("invalidate strobe length wrong");
    property p_mon; mon_r |-> pins_o.lru_update_n; endproperty
    a_mon: assert property (p_mon) else $error("monitor lookup touched lru");
    property p_alloc;
        s_cpu_look ##0 (alloc_r && !rec_r && resp_i.match_n) |-> ##[1:12] !pins_o.store_n;
    endproperty
    a_alloc: assert property (p_alloc) else $error("no tag write after miss");
    property p_rec;
        s_cpu_look ##0 (rec_r && !resp_i.integrity_err_n) |-> ##[1:12] !pins_o.flush_all_n;
    endproperty
    a_rec: assert property (p_rec) else $error("no purge after integrity error");
    property p_rd; $rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o; endproperty
    a_rd: assert property (p_rd) else $error("read wait state wrong");
    property p_stall;
        avs_write_i && avs_address_i == REG_CTRL && !(pins_o.store_n && pins_o.flush_all_n)
            |-> avs_waitrequest_o;
    endproperty
    a_stall: assert property (p_stall) else $error("command taken while busy");
endmodule : ctlh_tag_host_monitor
bind ctlh_tag_host ctlh_tag_host_monitor u_mon (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_waitrequest_o(avs_waitrequest_o), .pins_o(pins_o), .resp_i(resp_i));
